// ==== design/fsp_defs.svh ====
// constants for the flash security status and protect select block
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// ==================================================
// command codes
`define FSP_OP_WR_ENABLE   8'h06
`define FSP_OP_WRDI        8'h04
`define FSP_OP_SEC_READ    8'h2B
`define FSP_OP_SEC_WRITE   8'h2F
`define FSP_OP_MODE_SEL    8'h68
`define FSP_OP_ENSO        8'hB1
`define FSP_OP_EXSO        8'hC1
`define FSP_OP_GANG_LOCK   8'h7E
`define FSP_OP_GANG_OPEN   8'h98
`define FSP_OP_PLOCK_SET   8'hE3
`define FSP_OP_PLOCK_CLR   8'hE4
`define FSP_OP_VLOCK_WR    8'hE1
`define FSP_OP_MASK_WR     8'hE5
// ==================================================
// security status bit positions
`define FSP_SEC_PMS        7
`define FSP_SEC_EFAIL      6
`define FSP_SEC_PFAIL      5
`define FSP_SEC_RSVD       4
`define FSP_SEC_ESUSP      3
`define FSP_SEC_PSUSP      2
`define FSP_SEC_LOCKDOWN   1
`define FSP_SEC_FACT       0
// ==================================================
// frame lengths in serial clock edges
`define FSP_LEN_OP         6'd8
`define FSP_LEN_MASK       6'd16
`define FSP_LEN_ADDR       6'd40
`define FSP_LEN_ADDR_DATA  6'd48
// ==================================================
// protection units: 16 bottom sectors, 510 middle blocks, 16 top sectors
`define FSP_UNITS          542
`define FSP_TOP_BLK        9'h1FF
`define FSP_TOP_BASE       10'd526
`define FSP_MID_BASE       10'd15
`define FSP_BP_ALL         4'd10
`endif

// ==== design/fsp_pkg.sv ====
// types for the flash security status and protect select block
package fsp_pkg;
  // ==================================================
  // serial frame state
  typedef enum logic [0:0] {
    FSP_FR_IDLE,
    FSP_FR_SHIFT
  } fsp_frame_e;
  typedef logic [9:0] fsp_unit_t;
endpackage : fsp_pkg

// ==== design/fsp_security_protect.sv ====
// security status register and write protection selection of a serial flash
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defs.svh"

module fsp_security_protect
  import fsp_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // serial pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        write_protect_pin_n,
  output var  logic        so_q,
  output var  logic        so_oe_q,
  // straps and status register inputs
  input  wire logic        factory_otp_lock,
  input  wire logic [3:0]  block_protect_level,
  // flash core events
  input  wire logic        erase_fail_evt,
  input  wire logic        program_fail_evt,
  input  wire logic        op_ok_evt,
  input  wire logic        erase_suspend_evt,
  input  wire logic        erase_resume_evt,
  input  wire logic        program_suspend_evt,
  input  wire logic        program_resume_evt,
  input  wire logic        program_start,
  // protection query from the flash core
  input  wire logic [24:0] chk_addr,
  output var  logic        chk_protected_q,
  output var  logic        array_blocked_q,
  // state
  output var  logic [7:0]  security_status_q,
  output var  logic        write_enable_latch_q,
  output var  logic        otp_mode_q
);

  // ==================================================
  // pin synchronisers
  logic [2:0]  sclk_sync_q;
  logic [2:0]  cs_sync_q;
  logic [1:0]  si_sync_q;
  logic [1:0]  wp_sync_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic        cs_low;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_sync_q <= 3'h0;
      cs_sync_q   <= 3'h7;
      si_sync_q   <= 2'h0;
      wp_sync_q   <= 2'h3;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      cs_sync_q   <= {cs_sync_q[1:0], cs_n};
      si_sync_q   <= {si_sync_q[0], si};
      wp_sync_q   <= {wp_sync_q[0], write_protect_pin_n};
    end
  end

  // only stages 1 and 2 feed logic; stage 0 goes to stage 1 alone
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign cs_rise   = cs_sync_q[1] & ~cs_sync_q[2];
  assign cs_fall   = ~cs_sync_q[1] & cs_sync_q[2];
  assign cs_low    = ~cs_sync_q[2];

  // ==================================================
  // frame shifter
  fsp_frame_e  frame_q;
  logic [5:0]  bit_cnt_q;
  logic [47:0] shift_q;
  logic [7:0]  op_q;
  logic [2:0]  out_idx_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      frame_q   <= FSP_FR_IDLE;
      bit_cnt_q <= 6'h00;
      shift_q   <= 48'h0;
      op_q      <= 8'h00;
    end else begin
      case (frame_q)
        FSP_FR_IDLE: begin
          if (cs_fall) begin
            frame_q   <= FSP_FR_SHIFT;
            bit_cnt_q <= 6'h00;
            op_q      <= 8'h00;
          end
        end
        FSP_FR_SHIFT: begin
          if (cs_rise) begin
            frame_q <= FSP_FR_IDLE;
          end else if (sclk_rise) begin
            shift_q <= {shift_q[46:0], si_sync_q[1]};
            if (bit_cnt_q != 6'h3F) begin
              bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            if (bit_cnt_q == `FSP_LEN_OP - 6'h01) begin
              op_q <= {shift_q[6:0], si_sync_q[1]};
            end
          end
        end
        default: frame_q <= FSP_FR_IDLE;
      endcase
    end
  end

  // ==================================================
  // status read-out on falling serial clock
  logic [7:0]  sec_val;
  logic        reading;

  assign reading = (frame_q == FSP_FR_SHIFT) && cs_low && (op_q == `FSP_OP_SEC_READ)
                   && (bit_cnt_q >= `FSP_LEN_OP);

  // each bit is taken live, so a read during a busy operation shows current flags
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      so_q      <= 1'b0;
      so_oe_q   <= 1'b0;
      out_idx_q <= 3'h0;
    end else if (!cs_low || frame_q == FSP_FR_IDLE) begin
      so_oe_q   <= 1'b0;
      out_idx_q <= 3'h0;
    end else if (reading && sclk_fall) begin
      so_oe_q   <= 1'b1;
      so_q      <= sec_val[3'h7 - out_idx_q];
      out_idx_q <= out_idx_q + 3'h1;
    end
  end

  // ==================================================
  // command decode at frame end
  logic        exec;
  logic        len_op;
  logic        cmd_wr_en;
  logic        cmd_wrdi;
  logic        cmd_sec_wr;
  logic        cmd_mode_sel;
  logic        cmd_enso;
  logic        cmd_exso;
  logic        cmd_gang_lock;
  logic        cmd_gang_open;
  logic        cmd_pset;
  logic        cmd_pclr;
  logic        cmd_vwr;
  logic        cmd_mask;
  logic        sector_mode;
  logic        lock_ok;
  fsp_unit_t   cmd_unit;

  // a frame that does not end on its exact bit count is rejected
  assign exec        = (frame_q == FSP_FR_SHIFT) && cs_rise;
  assign len_op      = exec && (bit_cnt_q == `FSP_LEN_OP);
  assign cmd_wr_en   = len_op && (op_q == `FSP_OP_WR_ENABLE);
  assign cmd_wrdi    = len_op && (op_q == `FSP_OP_WRDI);
  assign cmd_sec_wr  = len_op && (op_q == `FSP_OP_SEC_WRITE) && write_enable_latch_q;
  assign cmd_mode_sel = len_op && (op_q == `FSP_OP_MODE_SEL) && write_enable_latch_q;
  assign cmd_enso    = len_op && (op_q == `FSP_OP_ENSO);
  assign cmd_exso    = len_op && (op_q == `FSP_OP_EXSO);
  assign sector_mode = security_status_q[`FSP_SEC_PMS];
  assign lock_ok     = sector_mode && write_enable_latch_q && !otp_mode_q;
  assign cmd_gang_lock = lock_ok && len_op && (op_q == `FSP_OP_GANG_LOCK);
  assign cmd_gang_open = lock_ok && len_op && (op_q == `FSP_OP_GANG_OPEN);
  assign cmd_pclr    = lock_ok && len_op && (op_q == `FSP_OP_PLOCK_CLR);
  assign cmd_pset    = lock_ok && exec && (bit_cnt_q == `FSP_LEN_ADDR)
                       && (op_q == `FSP_OP_PLOCK_SET);
  assign cmd_vwr     = lock_ok && exec && (bit_cnt_q == `FSP_LEN_ADDR_DATA)
                       && (op_q == `FSP_OP_VLOCK_WR);
  assign cmd_mask    = sector_mode && exec && (bit_cnt_q == `FSP_LEN_MASK)
                       && (op_q == `FSP_OP_MASK_WR);
  assign cmd_unit    = unit_of(cmd_vwr ? shift_q[32:8] : shift_q[24:0]);

  // 4KB sectors in the lowest and highest 64KB, 64KB blocks in between
  function automatic fsp_unit_t unit_of(input logic [24:0] a);
    fsp_unit_t u;
    u = 10'd0;
    if (a[24:16] == 9'h000) begin
      u = {6'h00, a[15:12]};
    end else if (a[24:16] == `FSP_TOP_BLK) begin
      u = `FSP_TOP_BASE + {6'h00, a[15:12]};
    end else begin
      u = `FSP_MID_BASE + {1'b0, a[24:16]};
    end
    return u;
  endfunction : unit_of

  // ==================================================
  // write enable latch and secured area mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      write_enable_latch_q <= 1'b0;
    end else if (cmd_wr_en) begin
      write_enable_latch_q <= 1'b1;
    end else if (cmd_wrdi || cmd_sec_wr || cmd_mode_sel || cmd_gang_lock || cmd_gang_open
                 || cmd_pset || cmd_pclr || cmd_vwr) begin
      write_enable_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      otp_mode_q <= 1'b0;
    end else if (cmd_enso) begin
      otp_mode_q <= 1'b1;
    end else if (cmd_exso) begin
      otp_mode_q <= 1'b0;
    end
  end

  // ==================================================
  // security status bits; a set beats a clear in the same cycle
  logic        fact_cap_q;
  logic        efail_q;
  logic        pfail_q;
  logic        esusp_q;
  logic        psusp_q;
  logic        lockdown_q;
  logic        pms_q;
  logic        fact_q;

  // failure flags feed nothing but the status readout
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      efail_q <= 1'b0;
      pfail_q <= 1'b0;
    end else begin
      if (erase_fail_evt) begin
        efail_q <= 1'b1;
      end else if (op_ok_evt) begin
        efail_q <= 1'b0;
      end
      if (program_fail_evt || (program_start && chk_protected_q)) begin
        pfail_q <= 1'b1;
      end else if (op_ok_evt) begin
        pfail_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      esusp_q <= 1'b0;
      psusp_q <= 1'b0;
    end else begin
      if (erase_suspend_evt) begin
        esusp_q <= 1'b1;
      end else if (erase_resume_evt) begin
        esusp_q <= 1'b0;
      end
      if (program_suspend_evt) begin
        psusp_q <= 1'b1;
      end else if (program_resume_evt) begin
        psusp_q <= 1'b0;
      end
    end
  end

  // one-time bits: only ever set
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lockdown_q <= 1'b0;
      pms_q      <= 1'b0;
    end else begin
      if (cmd_sec_wr) begin
        lockdown_q <= 1'b1;
      end
      if (cmd_mode_sel) begin
        pms_q <= 1'b1;
      end
    end
  end

  // the strap is caught on the first edge after reset release
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fact_q     <= 1'b0;
      fact_cap_q <= 1'b1;
    end else if (fact_cap_q) begin
      fact_q     <= factory_otp_lock;
      fact_cap_q <= 1'b0;
    end
  end

  assign sec_val = {pms_q, efail_q, pfail_q, 1'b0, esusp_q, psusp_q, lockdown_q, fact_q};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      security_status_q <= 8'h00;
    end else begin
      security_status_q <= sec_val;
    end
  end

  // ==================================================
  // per-unit lock bits
  logic [`FSP_UNITS-1:0] plock_q;
  logic [`FSP_UNITS-1:0] vlock_q;
  logic                  mask_q;

  // persistent locks have no lock-down here, so they stay writable
  genvar gi;
  generate
    for (gi = 0; gi < `FSP_UNITS; gi++) begin : g_unit
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          vlock_q[gi] <= 1'b1;
          plock_q[gi] <= 1'b0;
        end else begin
          if (cmd_gang_lock) begin
            vlock_q[gi] <= 1'b1;
          end else if (cmd_gang_open) begin
            vlock_q[gi] <= 1'b0;
          end else if (cmd_vwr && cmd_unit == fsp_unit_t'(gi)) begin
            vlock_q[gi] <= shift_q[0];
          end
          if (cmd_pclr) begin
            plock_q[gi] <= 1'b0;
          end else if (cmd_pset && cmd_unit == fsp_unit_t'(gi)) begin
            plock_q[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // mask at 1 lets persistent locks protect; 0 masks them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_q <= 1'b1;
    end else if (cmd_mask) begin
      mask_q <= shift_q[0];
    end
  end

  // ==================================================
  // protection decision
  fsp_unit_t   chk_unit;
  logic        bp_prot;
  logic        sec_prot;
  logic [9:0]  bp_span;

  assign chk_unit = unit_of(chk_addr);
  // level n protects the top 2^(n-1) blocks; level 10 and up protects all
  assign bp_span  = 10'd1 << (block_protect_level - 4'd1);
  assign bp_prot  = (block_protect_level >= `FSP_BP_ALL) ||
                    ((block_protect_level != 4'd0) &&
                     ({1'b0, chk_addr[24:16]} >= (10'd512 - bp_span)));
  assign sec_prot = !wp_sync_q[1] || vlock_q[chk_unit] || (plock_q[chk_unit] && mask_q);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chk_protected_q <= 1'b1;
      array_blocked_q <= 1'b0;
    end else begin
      chk_protected_q <= sector_mode ? sec_prot : bp_prot;
      array_blocked_q <= otp_mode_q;
    end
  end

  // ==================================================
  // checks
  property p_efail;
    @(posedge ref_clk) disable iff (srst)
      erase_fail_evt |=> efail_q ##1 security_status_q[6];
  endproperty
  a_efail: assert property (p_efail) else $error("erase fail not recorded");

  property p_pfail_ok;
    @(posedge ref_clk) disable iff (srst)
      (op_ok_evt && !program_fail_evt && !(program_start && chk_protected_q))
      |=> !pfail_q;
  endproperty
  a_pfail_ok: assert property (p_pfail_ok) else $error("program fail not cleared");

  property p_esusp;
    @(posedge ref_clk) disable iff (srst)
      erase_suspend_evt |=> ##1 security_status_q[3];
  endproperty
  a_esusp: assert property (p_esusp) else $error("erase suspend not shown");

  property p_pms_sticky;
    @(posedge ref_clk) disable iff (srst)
      pms_q |=> pms_q [*8];
  endproperty
  a_pms_sticky: assert property (p_pms_sticky) else $error("mode select fell back");

  property p_otp_lockdown_flag_sticky;
    @(posedge ref_clk) disable iff (srst)
      $rose(lockdown_q) |-> $past(write_enable_latch_q) ##1 lockdown_q [*4];
  endproperty
  a_otp_lockdown_flag_sticky: assert property (p_otp_lockdown_flag_sticky) else $error("lockdown misbehaved");

  property p_rsvd;
    @(posedge ref_clk) disable iff (srst)
      !security_status_q[4];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_wp_all;
    @(posedge ref_clk) disable iff (srst)
      (sector_mode && !wp_sync_q[1]) |=> chk_protected_q;
  endproperty
  a_wp_all: assert property (p_wp_all) else $error("pin protect ignored");

  property p_bp_mode;
    @(posedge ref_clk) disable iff (srst)
      (!sector_mode && block_protect_level == 4'd0) |=> !chk_protected_q;
  endproperty
  a_bp_mode: assert property (p_bp_mode) else $error("level 0 protected");

  property p_otp_block;
    @(posedge ref_clk) disable iff (srst)
      cmd_enso |=> ##1 array_blocked_q;
  endproperty
  a_otp_block: assert property (p_otp_block) else $error("array not blocked");

endmodule : fsp_security_protect
`default_nettype wire

// ==== dv/flash_security_status_and_protect_select_test.sv ====
// self-checking bench for the security status and protect select block
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defs.svh"
module flash_security_status_and_protect_select_test;
  // ==================================================
  // signals
  logic        ref_clk = 1'b0;
  logic        srst;
  logic        wp_n;
  logic        fact;
  logic [3:0]  bp;
  logic [7:0]  evt;
  logic [24:0] addr;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        prot;
  logic        blk;
  logic [7:0]  sec;
  logic        write_enable_latch;
  logic        otp;
  int          n_fail     = 0;
  int          n_compared = 0;
  int          n_cycles   = 0;

  always #5 ref_clk = ~ref_clk;

  fsp_security_protect u_dut (
    .ref_clk(ref_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .write_protect_pin_n(wp_n), .so_q(so), .so_oe_q(so_oe),
    .factory_otp_lock(fact), .block_protect_level(bp),
    .erase_fail_evt(evt[0]), .program_fail_evt(evt[1]), .op_ok_evt(evt[2]),
    .erase_suspend_evt(evt[3]), .erase_resume_evt(evt[4]),
    .program_suspend_evt(evt[5]), .program_resume_evt(evt[6]),
    .program_start(evt[7]), .chk_addr(addr), .chk_protected_q(prot),
    .array_blocked_q(blk), .security_status_q(sec),
    .write_enable_latch_q(write_enable_latch), .otp_mode_q(otp)
  );

  fsp_host_model u_host (
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe)
  );

  // ==================================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic pulse(input int k);
    @(negedge ref_clk) evt[k] = 1'b1;
    @(negedge ref_clk) evt = 8'h00;
    repeat (3) @(negedge ref_clk);
  endtask : pulse

  task automatic cmd(input logic [47:0] v, input int n);
    logic [15:0] rd;
    @(negedge ref_clk);
    u_host.frame(v, n, 0, rd);
  endtask : cmd

  // write commands always follow a write enable frame
  task automatic wcmd(input logic [47:0] v, input int n);
    cmd({40'h0, `FSP_OP_WR_ENABLE}, 8);
    cmd(v, n);
  endtask : wcmd

  task automatic query(input logic [24:0] a, input logic exp, input string what);
    @(negedge ref_clk) addr = a;
    repeat (4) @(negedge ref_clk);
    check(what, {7'h00, prot}, {7'h00, exp});
  endtask : query

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // ==================================================
  // scenarios
  task automatic t_reset;
    check("status reset", sec, 8'h01);
    query(25'h0000000, 1'b0, "level 0 open");
  endtask : t_reset

  task automatic t_events;
    int set_k [4] = '{0, 1, 3, 5};
    int clr_k [4] = '{2, 2, 4, 6};
    int bitn  [4] = '{6, 5, 3, 2};
    for (int i = 0; i < 4; i++) begin
      pulse(set_k[i]);
      check("flag set", sec, 8'h01 | (8'h01 << bitn[i]));
      pulse(clr_k[i]);
      check("flag clear", sec, 8'h01);
    end
  endtask : t_events

  task automatic t_read;
    logic [15:0] rd;
    cmd({39'h0, `FSP_OP_WR_ENABLE, 1'b0}, 9);
    check("ragged frame", {7'h00, write_enable_latch}, 8'h00);
    pulse(0);
    u_host.frame({40'h0, `FSP_OP_SEC_READ}, 8, 16, rd);
    check("serial first", rd[15:8], 8'h41);
    check("serial again", rd[7:0], 8'h41);
    cmd({40'h0, `FSP_OP_WR_ENABLE}, 8);
    check("latch with fail", {7'h00, write_enable_latch}, 8'h01);
    pulse(2);
  endtask : t_read

  task automatic t_levels;
    cmd({40'h0, `FSP_OP_WRDI}, 8);
    wcmd({8'h00, `FSP_OP_PLOCK_SET, 32'h0000_0000}, 40);
    @(negedge ref_clk) bp = 4'd1;
    query(25'h1FF0000, 1'b1, "level 1 top");
    query(25'h1FEFFFF, 1'b0, "level 1 below");
    @(negedge ref_clk) bp = `FSP_BP_ALL;
    query(25'h0000000, 1'b1, "level all");
    @(negedge ref_clk) bp = 4'd0;
    query(25'h0000000, 1'b0, "level 0 lock ignored");
  endtask : t_levels

  task automatic t_select;
    // the refused lock frame of the level test left the latch set
    cmd({40'h0, `FSP_OP_WRDI}, 8);
    cmd({40'h0, `FSP_OP_MODE_SEL}, 8);
    check("select no latch", sec, 8'h01);
    wcmd({40'h0, `FSP_OP_MODE_SEL}, 8);
    check("select set", sec, 8'h81);
    query(25'h0000000, 1'b1, "locked at start");
    wcmd({40'h0, `FSP_OP_GANG_OPEN}, 8);
    query(25'h0000000, 1'b0, "gang open");
    @(negedge ref_clk) wp_n = 1'b0;
    query(25'h0000000, 1'b1, "pin low");
    @(negedge ref_clk) wp_n = 1'b1;
    wcmd({8'h00, `FSP_OP_PLOCK_SET, 32'h0000_1000}, 40);
    query(25'h0001000, 1'b1, "sector lock");
    query(25'h0000FFF, 1'b0, "next sector");
    wcmd({8'h00, `FSP_OP_PLOCK_SET, 32'h0003_4000}, 40);
    query(25'h003FFFF, 1'b1, "block lock");
    query(25'h0040000, 1'b0, "next block");
    wcmd({32'h0, `FSP_OP_MASK_WR, 8'h00}, 16);
    query(25'h0001000, 1'b0, "mask off");
    wcmd({32'h0, `FSP_OP_MASK_WR, 8'h01}, 16);
    query(25'h0001000, 1'b1, "mask back");
    wcmd({`FSP_OP_VLOCK_WR, 32'h0000_0000, 8'h01}, 48);
    query(25'h0000000, 1'b1, "volatile lock");
    wcmd({40'h0, `FSP_OP_PLOCK_CLR}, 8);
    query(25'h0001000, 1'b0, "persistent cleared");
    query(25'h0000000, 1'b1, "volatile kept");
  endtask : t_select

  task automatic t_otp;
    pulse(7);
    check("protected program", sec, 8'hA1);
    pulse(2);
    wcmd({40'h0, `FSP_OP_SEC_WRITE}, 8);
    check("lockdown", sec, 8'h83);
    cmd({40'h0, `FSP_OP_ENSO}, 8);
    check("array refused", {6'h00, otp, blk}, 8'h03);
    cmd({40'h0, `FSP_OP_EXSO}, 8);
    check("array back", {6'h00, otp, blk}, 8'h00);
    check("status kept", sec, 8'h83);
  endtask : t_otp

  // ==================================================
  // run
  always @(posedge ref_clk) begin
    n_cycles++;
    if (n_cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    fact = 1'b1;
    bp   = 4'd0;
    evt  = 8'h00;
    addr = 25'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) srst = 1'b0;
    repeat (6) @(negedge ref_clk);
    t_reset();
    t_events();
    t_read();
    t_levels();
    t_select();
    t_otp();
    stop_test();
  end
endmodule : flash_security_status_and_protect_select_test
`default_nettype wire

// ==== dv/fsp_host_model.sv ====
// host serial controller model that frames commands for the security block
`timescale 1ns/1ns
`default_nettype none
module fsp_host_model (
  // serial pins
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so,
  input  wire logic so_oe
);
  // ==================================================
  // framing
  // the link clock rests low between frames, 125 ns period inside them
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // shifts the low n bits of v msb first, then clocks rd_bits answer bits in
  task automatic frame(input logic [47:0] v, input int n, input int rd_bits,
                       output logic [15:0] rd);
    rd   = 16'h0000;
    cs_n = 1'b0;
    // frames start on a bench falling edge; this offset keeps every pin edge off ref_clk rise
    #97;
    for (int i = n - 1; i >= 0; i--) begin
      si = v[i];
      #62 sclk = 1'b1;
      #63 sclk = 1'b0;
    end
    // input line is released with no pull: show the inverse, never a stale copy
    si = ~si;
    for (int i = 0; i < rd_bits; i++) begin
      #62 sclk = 1'b1;
      rd = {rd[14:0], so & so_oe};
      #63 sclk = 1'b0;
    end
    #62 cs_n = 1'b1;
    #200;
  endtask : frame
endmodule : fsp_host_model
`default_nettype wire
